// ---- shared/dwd_pkg.sv ----
// Purpose: constants for the digital watchdog block
// Assumes: 100 MHz aclk, AXI4-Lite with 8-bit byte addresses
// Notes:   one package shared by the top design file and the bench
`default_nettype none
package dwd_pkg;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [7:0] ADDR_WDR   = 8'hD8;
    localparam logic [7:0] ADDR_ISR   = 8'hE0;
    localparam logic [7:0] ADDR_IMR   = 8'hE4;
    localparam logic [7:0] ADDR_STAT  = 8'hE8;
    // ----------------------------------------
    // field layout and reset values
    // ----------------------------------------
    localparam int         BIT_ARM    = 0;
    localparam int         BIT_SRT    = 1;
    localparam int         CNT_W      = 7;
    localparam logic [7:0] WDR_RST    = 8'hFE;
    localparam logic [6:0] CNT_RST    = 7'h7F;
    localparam int         EV_TIMEOUT = 0;
    localparam int         EV_WRAP    = 1;
    localparam int         EV_STOP    = 2;
    localparam int         EV_W       = 3;
    // ----------------------------------------
    // timing counts
    // ----------------------------------------
    localparam int         PRE_DIV    = 12;
    localparam int         STEP_DIV   = 256;
    localparam int         RST_HOLD   = 2048;
    // ----------------------------------------
    // bus answers
    // ----------------------------------------
    localparam logic [1:0] RESP_OKAY  = 2'h0;
    localparam logic [1:0] RESP_SLV   = 2'h2;
endpackage
`default_nettype wire

// ---- design/dwd_prescale.sv ----
// Purpose: divide aclk into a one-cycle tick every DIV cycles
// Assumes: run low freezes the phase, clr restarts it
// Notes:   tick is registered
`timescale 1ns/1ps
`default_nettype none
module dwd_prescale #(
    parameter int DIV = 12
) (
    // clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // control
    input  wire logic clr,
    input  wire logic run,
    // tick out
    output logic      tick
);
    localparam int W = $clog2(DIV);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic         tick;
    } dwd_pre_state_t;

    dwd_pre_state_t s_q;
    dwd_pre_state_t s_d;

    initial begin
        if (DIV < 2) begin
            $error("dwd_prescale: DIV must be at least 2");
        end
    end

    always_comb begin
        s_d      = s_q;
        s_d.tick = 1'b0;
        if (clr) begin
            s_d.cnt = '0;
        end else if (run) begin
            if (s_q.cnt == W'(DIV - 1)) begin
                s_d.cnt  = '0;
                s_d.tick = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt + W'(1);
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick = s_q.tick;
endmodule
`default_nettype wire

// ---- design/dwd_top.sv ----
// Purpose: digital watchdog with reversed-bit count register on AXI4-Lite
// Assumes: stop_req, wake_irq, nmi_high synchronous to aclk
// Notes:   mcu_reset_q is the internal reset request to the rest of the chip
//
// How it works
// RL1 - downcounter decrements; count falling from 40h to 3Fh raises the internal reset
// RL2 - a write to the count register reloads and restarts the count
// RL3 - with software activation the watchdog idles until the arm bit is set
// RL4 - once armed it cannot be disarmed; only a reset clears it
// RL5 - stop while inactive enters true stop mode
// RL6 - hardware activation: always active, stop acts as wait, count runs
// RL7 - external stop control with nmi low: stop acts as wait
// RL8 - external stop control with nmi high: counter frozen, stop mode
// RL9 - a wake interrupt leaves stop and the count resumes
// RL10 - reset loads FEh: arm clear, six count bits and reset bit set
// RL11 - the reset bit falling from one to zero resets at once
// RL12 - register bit 7 holds count lsb, bit 2 its msb
// RL13 - reset fires when count bit 6 falls to zero
// RL14 - 64 periods from 3072 to 196608 clock cycles
// RL15 - the counter runs on the clock divided by twelve
// RL16 - hardware activation reads the arm bit as one, not writable
// RL17 - unarmed, the counter is a free 7-bit timer without reset
// RL18 - a watchdog reset holds like a pin reset, with stabilisation delay
// RL19 - a read returns live count in reversed bits plus arm bit
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module dwd_top
    import dwd_pkg::*;
#(
    parameter int RST_HOLD_CYC = dwd_pkg::RST_HOLD
) (
    // clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // hardware options and core events
    input  wire logic       opt_hw_activate,
    input  wire logic       opt_ext_stop,
    input  wire logic       nmi_high,
    input  wire logic       stop_req,
    input  wire logic       wake_irq,
    // write address
    input  wire logic       awvalid,
    output logic            awready,
    input  wire logic [7:0] awaddr,
    // write data
    input  wire logic       wvalid,
    output logic            wready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0] wstrb,
    // write response
    output logic            bvalid,
    input  wire logic       bready,
    output logic [1:0]      bresp,
    // read address
    input  wire logic       arvalid,
    output logic            arready,
    input  wire logic [7:0] araddr,
    // read data
    output logic            rvalid,
    input  wire logic       rready,
    output logic [31:0]     rdata,
    output logic [1:0]      rresp,
    // outputs to the chip
    output logic            mcu_reset_q,
    output logic            stop_mode_q,
    output logic            wait_mode_q,
    output logic            irq
);
    import dwd_pkg::*;

    typedef struct packed {
        logic [6:0]  cnt;
        logic        arm;
        logic [7:0]  step;
        logic        stop;
        logic        waitm;
        logic        rst;
        logic [11:0] hold;
        logic [2:0]  isr;
        logic [2:0]  imr;
        logic        irq;
        logic        aw_got;
        logic [7:0]  awa;
        logic        w_got;
        logic [7:0]  wd;
        logic        wen;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } dwd_state_t;

    dwd_state_t s_q;
    dwd_state_t s_d;
    logic       tick;
    logic       act;
    logic       step_wrap;
    logic       wr_fire;
    logic       wr_wdr;
    logic [6:0] wdr_cnt;
    logic [7:0] wdr_view;

    initial begin
        if (RST_HOLD_CYC < 1 || RST_HOLD_CYC > 4096) begin
            $error("dwd_top: RST_HOLD_CYC must be 1 to 4096");
        end
    end

    // ----------------------------------------
    // divide by twelve
    // ----------------------------------------
    dwd_prescale #(
        .DIV     (PRE_DIV)
    ) u_pre (
        .aclk    (aclk),
        .aresetn (aresetn),
        .clr     (s_q.rst || wr_wdr),
        .run     (!s_q.stop),
        .tick    (tick)
    );

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    always_comb begin
        act       = s_q.arm || opt_hw_activate;
        // a tick launched just before stop must not move a frozen count
        step_wrap = tick && !s_q.stop && (s_q.step == 8'(STEP_DIV - 1));
        wr_fire   = s_q.aw_got && s_q.w_got && !s_q.bvalid;
        wr_wdr    = wr_fire && s_q.wen && (s_q.awa == ADDR_WDR) && !s_q.rst;
        for (int i = 0; i < 6; i++) begin
            wdr_cnt[i]     = s_q.wd[7 - i]; // see RL12
            wdr_view[7 - i] = s_q.cnt[i];   // see RL19
        end
        wdr_cnt[6]       = s_q.wd[BIT_SRT];
        wdr_view[BIT_SRT] = s_q.cnt[6];
        wdr_view[BIT_ARM] = act;           // see RL16
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        logic [2:0] ev;
        logic       act_n;
        ev   = '0;
        s_d  = s_q;
        act_n = 1'b0;

        // write channels
        if (s_q.awready && awvalid) begin
            s_d.aw_got  = 1'b1;
            s_d.awa     = awaddr;
            s_d.awready = 1'b0;
        end
        if (s_q.wready && wvalid) begin
            s_d.w_got  = 1'b1;
            s_d.wd     = wdata[7:0];
            s_d.wen    = wstrb[0];
            s_d.wready = 1'b0;
        end
        if (wr_fire) begin
            s_d.aw_got = 1'b0;
            s_d.w_got  = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp  = RESP_OKAY;
            case (s_q.awa)
                ADDR_WDR, ADDR_ISR, ADDR_STAT: begin
                end
                ADDR_IMR: begin
                    if (s_q.wen) begin
                        s_d.imr = s_q.wd[EV_W-1:0];
                    end
                end
                default: begin
                    s_d.bresp = RESP_SLV;
                end
            endcase
        end
        if (s_q.bvalid && bready) begin
            s_d.bvalid  = 1'b0;
            s_d.awready = 1'b1;
            s_d.wready  = 1'b1;
        end

        // read channels
        if (s_q.arready && arvalid) begin
            s_d.arready = 1'b0;
            s_d.rvalid  = 1'b1;
            s_d.rresp   = RESP_OKAY;
            s_d.rdata   = '0;
            case (araddr)
                ADDR_WDR: begin
                    s_d.rdata[7:0] = wdr_view;
                end
                ADDR_ISR: begin
                    s_d.rdata[EV_W-1:0] = s_q.isr;
                    s_d.isr             = '0;
                end
                ADDR_IMR: begin
                    s_d.rdata[EV_W-1:0] = s_q.imr;
                end
                ADDR_STAT: begin
                    s_d.rdata[3:0] = {s_q.stop, s_q.waitm, s_q.rst, act};
                end
                default: begin
                    s_d.rresp = RESP_SLV;
                end
            endcase
        end
        if (s_q.rvalid && rready) begin
            s_d.rvalid  = 1'b0;
            s_d.arready = 1'b1;
        end

        // watchdog core
        if (s_q.rst) begin
            // stabilisation hold, then release
            s_d.cnt   = CNT_RST; // see RL10
            s_d.arm   = 1'b0;
            s_d.step  = '0;
            s_d.stop  = 1'b0;
            s_d.waitm = 1'b0;
            if (s_q.hold == 12'h000) begin
                s_d.rst = 1'b0;
            end else begin
                s_d.hold = s_q.hold - 12'h001; // see RL18
            end
        end else begin
            if (tick && !s_q.stop) begin
                s_d.step = s_q.step + 8'h01; // see RL14, RL8
            end
            if (step_wrap) begin
                s_d.cnt = s_q.cnt - 7'h01; // see RL1, RL15, RL17
            end
            if (wr_wdr) begin
                s_d.cnt  = wdr_cnt;  // see RL2
                s_d.step = '0;
                s_d.arm  = s_q.arm || s_q.wd[BIT_ARM]; // see RL3, RL4
            end
            // leaving stop or wait
            if (wake_irq) begin
                s_d.stop  = 1'b0; // see RL9
                s_d.waitm = 1'b0;
            end
            if (stop_req && !s_q.stop && !s_q.waitm) begin
                if (!act) begin
                    s_d.stop = 1'b1; // see RL5
                    ev[EV_STOP] = 1'b1;
                end else if (opt_ext_stop && nmi_high) begin
                    s_d.stop = 1'b1; // see RL8
                    ev[EV_STOP] = 1'b1;
                end else begin
                    s_d.waitm = 1'b1; // see RL6, RL7
                end
            end
            act_n = s_d.arm || opt_hw_activate;
            if (s_q.cnt[6] && !s_d.cnt[6]) begin
                if (act_n) begin
                    s_d.rst  = 1'b1; // see RL11, RL13
                    s_d.hold = 12'(RST_HOLD_CYC - 1);
                    ev[EV_TIMEOUT] = 1'b1;
                end else begin
                    ev[EV_WRAP] = 1'b1;
                end
            end
        end

        // sticky events, set wins over read clear
        s_d.isr = s_d.isr | ev;
        s_d.irq = |(s_d.isr & s_d.imr);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q         <= '0;
            s_q.cnt     <= CNT_RST;
            s_q.awready <= 1'b1;
            s_q.wready  <= 1'b1;
            s_q.arready <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign awready     = s_q.awready;
    assign wready      = s_q.wready;
    assign bvalid      = s_q.bvalid;
    assign bresp       = s_q.bresp;
    assign arready     = s_q.arready;
    assign rvalid      = s_q.rvalid;
    assign rdata       = s_q.rdata;
    assign rresp       = s_q.rresp;
    assign mcu_reset_q = s_q.rst;
    assign stop_mode_q = s_q.stop;
    assign wait_mode_q = s_q.waitm;
    assign irq         = s_q.irq;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    logic [12:0] hold_len;

    always_ff @(posedge aclk) begin
        if (!aresetn || !s_q.rst) begin
            hold_len <= '0;
        end else begin
            hold_len <= hold_len + 13'h0001;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    count_zero_a: assert property ( // see RL1
        (!s_q.rst && act && s_q.cnt == 7'h40 && step_wrap && !wr_wdr
         && !stop_req) |=> s_q.rst ##1 (s_q.cnt == CNT_RST && !s_q.arm))
        else $error("count to zero did not reset");
    hold_len_a: assert property ( // see RL18
        $fell(s_q.rst) |-> $past(hold_len) == 13'(RST_HOLD_CYC - 1))
        else $error("reset hold has wrong length");
    reload_val_a: assert property ( // see RL2
        (wr_wdr && s_q.wd[BIT_SRT]) |=> s_q.cnt == $past(wdr_cnt) && s_q.step == 8'h00)
        else $error("reload did not load written count");
    arm_keep_a: assert property ( // see RL4
        (s_q.arm && !s_q.rst) |=> (s_q.arm || s_q.rst))
        else $error("armed watchdog was disarmed");
    idle_no_rst_a: assert property ( // see RL3
        (!act && !wr_wdr && !s_q.rst) |=> !s_q.rst)
        else $error("inactive watchdog raised reset");
    true_stop_a: assert property ( // see RL5
        (stop_req && !act && !s_q.stop && !s_q.waitm && !s_q.rst && !wake_irq)
        |=> s_q.stop && !s_q.waitm)
        else $error("inactive stop did not enter stop");
    stop_wait_a: assert property ( // see RL6
        (stop_req && act && !(opt_ext_stop && nmi_high) && !s_q.stop
         && !s_q.waitm && !s_q.rst) |=> s_q.waitm && !s_q.stop)
        else $error("active stop not taken as wait");
    freeze_cnt_a: assert property ( // see RL8
        (s_q.stop && !wake_irq && !wr_wdr && !s_q.rst)
        |=> $stable(s_q.cnt) && $stable(s_q.step))
        else $error("counter moved while frozen");
    wake_run_a: assert property ( // see RL9
        (s_q.stop && wake_irq && !s_q.rst) |=> !s_q.stop)
        else $error("wake did not leave stop");
    arm_read_a: assert property ( // see RL16
        (arready && arvalid && araddr == ADDR_WDR && opt_hw_activate)
        |=> rvalid && rdata[BIT_ARM])
        else $error("hardware option arm bit read as zero");
    irq_lvl_a: assert property (
        (|(s_q.isr & s_q.imr)) |-> irq)
        else $error("unmasked status without interrupt");

    timeout_c: cover property ($rose(s_q.rst));
    freeze_c:  cover property ($rose(s_q.stop) && act);
    wrap_c:    cover property (s_q.isr[EV_WRAP] && !act);
endmodule
`default_nettype wire

// ---- bench/dwd_top_tb_top.sv ----
// Purpose: self-checking bench for the digital watchdog block
// Assumes: AXI4-Lite register access, hold of four cycles for the chip reset
// Notes:   tasks speak the bus, tests are call sequences with expected values
`timescale 1ns/1ps
`default_nettype none
module dwd_top_tb_top;
    import dwd_pkg::*;
    localparam int HOLD = 4;
    logic        aclk;
    logic        aresetn;
    logic        opt_hw_activate;
    logic        opt_ext_stop;
    logic        nmi_high;
    logic        stop_req;
    logic        wake_irq;
    logic        awvalid;
    logic        awready;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic        wready;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic        bready;
    logic [1:0]  bresp;
    logic        arvalid;
    logic        arready;
    logic [7:0]  araddr;
    logic        rvalid;
    logic        rready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        mcu_reset_q;
    logic        stop_mode_q;
    logic        wait_mode_q;
    logic        irq;
    int          mismatches;
    int          samples_checked;
    int          cyc;
    int          rst_seen;
    int          n;
    logic [31:0] v1;
    logic [31:0] v2;
    logic [1:0]  r;
    // ----------------------------------------
    // design and clock
    // ----------------------------------------
    dwd_top #(.RST_HOLD_CYC(HOLD)) u_dwd_top (.aclk(aclk), .aresetn(aresetn),
        .opt_hw_activate(opt_hw_activate), .opt_ext_stop(opt_ext_stop),
        .nmi_high(nmi_high), .stop_req(stop_req), .wake_irq(wake_irq),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
        .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
        .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
        .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
        .rresp(rresp), .mcu_reset_q(mcu_reset_q), .stop_mode_q(stop_mode_q),
        .wait_mode_q(wait_mode_q), .irq(irq));
    always #5 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc++;
        if (mcu_reset_q === 1'b1) rst_seen++;
        if (cyc == 60000) begin
            fail("run took too long");
            conclude();
        end
    end
    // ----------------------------------------
    // report and compare tasks
    // ----------------------------------------
    task automatic fail(input string m);
        mismatches++;
        $display("[FAIL] %0t %s", $time, m);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) fail($sformatf("data %h expected %h", g, e));
    endtask
    task automatic chk_bit(input logic g, input logic e, input string m);
        samples_checked++;
        if (g !== e) fail(m);
    endtask
    task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
        samples_checked++;
        if (g !== e) fail($sformatf("response %h expected %h", g, e));
    endtask
    // ----------------------------------------
    // bus and pin tasks
    // ----------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] rs);
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        rs = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask
    task automatic wr_ok(input logic [7:0] a, input logic [7:0] d);
        logic [1:0] rs;
        wr(a, d, rs);
        chk_resp(rs, RESP_OKAY);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [31:0] d;
        logic [1:0]  rs;
        rd(a, d, rs);
        chk_resp(rs, RESP_OKAY);
        chk_word(d, {24'h0, e});
    endtask
    task automatic pulse(input int sel);
        @(posedge aclk);
        if (sel == 0) stop_req <= 1'b1;
        else wake_irq <= 1'b1;
        @(posedge aclk);
        stop_req <= 1'b0;
        wake_irq <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic wait_sig(input int sel, input logic lvl, input int mx, output int k);
        logic v;
        k = 0;
        do begin
            @(posedge aclk);
            k++;
            v = (sel == 0) ? mcu_reset_q : irq;
        end while (v !== lvl && k < mx);
        if (v !== lvl) fail("wait ran out");
    endtask
    task automatic do_reset();
        aresetn <= 1'b0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
    endtask
    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin
        {aclk, aresetn, opt_hw_activate, opt_ext_stop, nmi_high, stop_req} = 6'h0;
        {wake_irq, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
        {awaddr, araddr, wdata, wstrb} = 52'h0;
        {mismatches, samples_checked, cyc, rst_seen} = {4{32'h0}};
        wstrb = 4'hF;
        do_reset();
        rd_chk(ADDR_WDR, 8'hFE);
        rd_chk(ADDR_IMR, 8'h00);
        rd_chk(ADDR_STAT, 8'h00);
        rd(8'h10, v1, r);
        chk_resp(r, RESP_SLV);
        wr(8'h14, 8'h55, r);
        chk_resp(r, RESP_SLV);
        pulse(0);
        chk_bit(stop_mode_q, 1'b1, "inactive stop not taken");
        chk_bit(wait_mode_q, 1'b0, "inactive stop taken as wait");
        rd_chk(ADDR_STAT, 8'h08);
        pulse(1);
        chk_bit(stop_mode_q, 1'b0, "wake did not leave stop");
        rd_chk(ADDR_ISR, 8'h04);
        rd_chk(ADDR_ISR, 8'h00);
        wr_ok(ADDR_IMR, 8'h02);
        wr_ok(ADDR_WDR, 8'h02);
        wait_sig(1, 1'b1, 3200, n);
        rd_chk(ADDR_WDR, 8'hFC);
        chk_bit(rst_seen == 0, 1'b1, "timer mode raised reset");
        rd_chk(ADDR_ISR, 8'h02);
        repeat (2) @(posedge aclk);
        chk_bit(irq, 1'b0, "irq stayed after status read");
        wr_ok(ADDR_WDR, 8'h03);
        rd_chk(ADDR_STAT, 8'h01);
        repeat (2500) @(posedge aclk);
        wr_ok(ADDR_WDR, 8'h03);
        wait_sig(0, 1'b1, 3200, n);
        chk_bit(n >= 3066 && n <= 3080, 1'b1, "timeout period wrong");
        wait_sig(0, 1'b0, 50, n);
        chk_bit(n == HOLD, 1'b1, "reset hold length wrong");
        chk_bit(irq, 1'b0, "masked event raised irq");
        rd_chk(ADDR_WDR, 8'hFE);
        wr_ok(ADDR_IMR, 8'h01);
        repeat (2) @(posedge aclk);
        chk_bit(irq, 1'b1, "unmasked event gave no irq");
        wstrb <= 4'h0;
        wr_ok(ADDR_IMR, 8'h00);
        wstrb <= 4'hF;
        rd_chk(ADDR_IMR, 8'h01);
        rd_chk(ADDR_ISR, 8'h01);
        repeat (2) @(posedge aclk);
        chk_bit(irq, 1'b0, "irq stayed after status read");
        wr_ok(ADDR_WDR, 8'h03);
        wr_ok(ADDR_WDR, 8'hFE);
        rd_chk(ADDR_WDR, 8'hFF);
        wr_ok(ADDR_WDR, 8'hFD);
        wait_sig(0, 1'b1, 4, n);
        wait_sig(0, 1'b0, 50, n);
        rd_chk(ADDR_ISR, 8'h01);
        opt_hw_activate <= 1'b1;
        nmi_high <= 1'b1;
        do_reset();
        rd_chk(ADDR_WDR, 8'hFF);
        wr_ok(ADDR_WDR, 8'hFE);
        rd_chk(ADDR_WDR, 8'hFF);
        pulse(0);
        chk_bit(wait_mode_q, 1'b1, "stop not taken as wait");
        chk_bit(stop_mode_q, 1'b0, "stop entered with hardware option");
        rd(ADDR_WDR, v1, r);
        repeat (3100) @(posedge aclk);
        rd(ADDR_WDR, v2, r);
        chk_bit(v1 !== v2, 1'b1, "count stalled in wait");
        pulse(1);
        opt_ext_stop <= 1'b1;
        nmi_high <= 1'b0;
        pulse(0);
        chk_bit(wait_mode_q, 1'b1, "low pin stop not wait");
        chk_bit(stop_mode_q, 1'b0, "low pin stop froze count");
        pulse(1);
        nmi_high <= 1'b1;
        pulse(0);
        chk_bit(stop_mode_q, 1'b1, "high pin stop not taken");
        rd(ADDR_WDR, v1, r);
        repeat (3200) @(posedge aclk);
        rd(ADDR_WDR, v2, r);
        chk_word(v2, v1);
        pulse(1);
        chk_bit(stop_mode_q, 1'b0, "wake did not leave stop");
        repeat (3200) @(posedge aclk);
        rd(ADDR_WDR, v2, r);
        chk_bit(v1 !== v2, 1'b1, "count did not resume");
        conclude();
    end
endmodule
`default_nettype wire
